// file: rtl/acs_top.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "acs_regs.svh"
module acs_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] BE,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic CONV_CLK_IN,
  input wire logic [15:0] CH1_DATA,
  input wire logic CH1_OVR,
  input wire logic CH1_VALID,
  input wire logic [15:0] CH2_DATA,
  input wire logic CH2_OVR,
  input wire logic CH2_VALID,
  input wire logic CH1_POP,
  input wire logic CH2_POP,
  output logic [15:0] CH1_POP_DATA,
  output logic [15:0] CH2_POP_DATA,
  output logic CH1_EMPTY,
  output logic CH2_EMPTY,
  output logic CH1_FULL,
  output logic CH2_FULL,
  output logic CH1_STAB_EN,
  output logic CH2_STAB_EN,
  output logic CH1_CONV_CLK,
  output logic CH2_CONV_CLK
);
  logic [15:0] board_r;
  logic [15:0] csr1_r;
  logic [15:0] csr2_r;
  logic [31:0] rdata_r;
  logic clr1;
  logic clr2;
  logic [15:0] w_lo;
  logic [15:0] w_hi;
  logic [1:0] be_lo;
  logic [1:0] be_hi;
  logic ovr1_r;
  logic ovr2_r;
  logic div_r;
  acs_pkg::acs_sample_s smp1;
  acs_pkg::acs_sample_s smp2;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~m) | (d & m);
  endfunction

  // a 32-bit word at 8104H carries ch1 in the low half, ch2 in the high half
  assign w_lo = WDATA[15:0];
  assign w_hi = WDATA[31:16];
  assign be_lo = BE[1:0];
  assign be_hi = BE[3:2];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      board_r <= `ACS_BOARD_RESET;
    end else if (WR && ADDR[15:2] == `ACS_OFS_BOARD_CTRL >> 2 && !ADDR[1]) begin
      board_r <= merge(board_r, w_lo, be_lo, 16'hFFFF);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      csr1_r <= `ACS_CSR_RESET;
    end else if (WR && ADDR[15:2] == `ACS_OFS_CH1_CSR >> 2 && !ADDR[1]) begin
      csr1_r <= merge(csr1_r, w_lo, be_lo, `ACS_CSR_WR_MASK);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      csr2_r <= `ACS_CSR_RESET;
    end else if (WR && ADDR[15:2] == `ACS_OFS_CH2_CSR >> 2) begin
      csr2_r <= merge(csr2_r, (ADDR[1] ? w_lo : w_hi), (ADDR[1] ? be_lo : be_hi),
                      `ACS_CSR_WR_MASK);
    end
  end

  // fifo clear is a self-clearing write pulse
  assign clr1 = WR && ADDR[15:2] == `ACS_OFS_CH1_CSR >> 2 && !ADDR[1] && BE[0] &&
                WDATA[`ACS_BIT_FIFO_CLR];
  assign clr2 = WR && ADDR[15:2] == `ACS_OFS_CH2_CSR >> 2 &&
                (ADDR[1] ? (BE[0] && WDATA[`ACS_BIT_FIFO_CLR]) :
                           (BE[2] && WDATA[16 + `ACS_BIT_FIFO_CLR]));

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ovr1_r <= 1'b0;
      ovr2_r <= 1'b0;
    end else begin
      ovr1_r <= CH1_OVR;
      ovr2_r <= CH2_OVR;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_r <= 32'h00000000;
    end else if (RD) begin
      unique case (ADDR[15:1])
        `ACS_OFS_BOARD_CTRL >> 1: rdata_r <= {16'h0000, board_r};
        `ACS_OFS_CH1_CSR >> 1: rdata_r <= {csr2_r, csr1_r} |
                                          {7'h00, ovr2_r, 15'h0000, ovr1_r, 8'h00};
        `ACS_OFS_CH2_CSR >> 1: rdata_r <= {16'h0000, csr2_r} |
                                          {23'h000000, ovr2_r, 8'h00};
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end
  assign RDATA = rdata_r;

  assign CH1_STAB_EN = csr1_r[`ACS_BIT_STAB];
  assign CH2_STAB_EN = csr2_r[`ACS_BIT_STAB];

  // stabilized clock: toggle flop gives exact 50% duty at half the rate
  // reset lasts at least one converter clock period, so the divider sees it
  always_ff @(posedge CONV_CLK_IN) begin
    if (RESET) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end
  assign CH1_CONV_CLK = CH1_STAB_EN ? div_r : CONV_CLK_IN;
  assign CH2_CONV_CLK = CH2_STAB_EN ? div_r : CONV_CLK_IN;

  assign smp1 = '{data: CH1_DATA, ovr: CH1_OVR};
  assign smp2 = '{data: CH2_DATA, ovr: CH2_OVR};

  acs_chan u_ch1 (
    .clk(CLK),
    .reset(RESET),
    .store_en(board_r[`ACS_BIT_STORE_CH1]),
    .fifo_clr(clr1),
    .twos_comp(csr1_r[`ACS_BIT_FORMAT]),
    .smp(smp1),
    .smp_valid(CH1_VALID),
    .pop(CH1_POP),
    .pop_data(CH1_POP_DATA),
    .empty(CH1_EMPTY),
    .full(CH1_FULL)
  );

  acs_chan u_ch2 (
    .clk(CLK),
    .reset(RESET),
    .store_en(board_r[`ACS_BIT_STORE_CH2]),
    .fifo_clr(clr2),
    .twos_comp(csr2_r[`ACS_BIT_FORMAT]),
    .smp(smp2),
    .smp_valid(CH2_VALID),
    .pop(CH2_POP),
    .pop_data(CH2_POP_DATA),
    .empty(CH2_EMPTY),
    .full(CH2_FULL)
  );
endmodule // acs_top
`default_nettype wire

// file: rtl/acs_regs.svh
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_OFS_BOARD_CTRL 16'h8100
`define ACS_OFS_CH1_CSR 16'h8104
`define ACS_OFS_CH2_CSR 16'h8106
`define ACS_BIT_FORMAT 1
`define ACS_BIT_STAB 2
`define ACS_BIT_FIFO_CLR 5
`define ACS_BIT_OVERLOAD 8
`define ACS_BIT_STORE_CH1 5
`define ACS_BIT_STORE_CH2 6
`define ACS_CSR_WR_MASK 16'h0006
`define ACS_CSR_RESET 16'h0000
`define ACS_BOARD_RESET 16'h0000
`define ACS_FIFO_AW 4
`define ACS_FIFO_DEPTH 16
`endif

// file: rtl/acs_pkg.sv
package acs_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } acs_bus_s;
  typedef struct packed {
    logic [15:0] data;
    logic ovr;
  } acs_sample_s;
endpackage

// file: rtl/acs_mem.sv
`timescale 1ns/100ps
`default_nettype none
module acs_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:15];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule // acs_mem
`default_nettype wire

// file: rtl/acs_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_regs.svh"
module acs_chan (
  input wire logic clk,
  input wire logic reset,
  input wire logic store_en,
  input wire logic fifo_clr,
  input wire logic twos_comp,
  input wire acs_pkg::acs_sample_s smp,
  input wire logic smp_valid,
  input wire logic pop,
  output logic [15:0] pop_data,
  output logic empty,
  output logic full
);
  logic [`ACS_FIFO_AW:0] wp_r;
  logic [`ACS_FIFO_AW:0] rp_r;
  logic push;
  logic [15:0] fmt;
  assign empty = (wp_r == rp_r);
  assign full = (wp_r[`ACS_FIFO_AW] != rp_r[`ACS_FIFO_AW]) &&
                (wp_r[`ACS_FIFO_AW-1:0] == rp_r[`ACS_FIFO_AW-1:0]);
  assign push = smp_valid && store_en && !full;
  assign fmt = twos_comp ? {~smp.data[15], smp.data[14:0]} : smp.data;
  always_ff @(posedge clk) begin
    if (reset || fifo_clr) begin
      wp_r <= '0;
    end else if (push) begin
      wp_r <= wp_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || fifo_clr) begin
      rp_r <= '0;
    end else if (pop && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
  acs_mem u_mem (
    .clk(clk),
    .we(push),
    .waddr(wp_r[`ACS_FIFO_AW-1:0]),
    .wdata(fmt),
    .raddr(rp_r[`ACS_FIFO_AW-1:0]),
    .rdata(pop_data)
  );
endmodule // acs_chan
`default_nettype wire

// file: tb/acs_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
module acs_conv_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] val,
  output logic [15:0] data,
  output logic valid
);
  // outside a sample the bus inverts its previous value every cycle
  always_ff @(posedge clk) begin
    valid <= go;
    data <= go ? val : ~data;
  end
endmodule // acs_conv_model
`default_nettype wire

// file: tb/acs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acs_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] BE,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic CH1_OVR,
  input wire logic CH1_VALID,
  input wire logic CH1_EMPTY,
  input wire logic CH1_STAB_EN,
  input wire logic CH2_STAB_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence csr1_wr;
    WR && ADDR == 16'h8104 && BE[0];
  endsequence
  rdata_idle_a: assert property (!RD |=> RDATA == 32'h0) else $error("rdata not idle");
  stab_set_a: assert property (csr1_wr ##0 WDATA[2] |=> CH1_STAB_EN) else $error("stab on");
  stab_clr_a: assert property (csr1_wr ##0 !WDATA[2] |=> !CH1_STAB_EN) else $error("stab off");
  ch2_stab_a: assert property (WR && ADDR == 16'h8106 && BE[0] |=> CH2_STAB_EN == $past(WDATA[2]))
    else $error("ch2 stab");
  stab_hold_a: assert property (!WR |=> $stable(CH1_STAB_EN) && $stable(CH2_STAB_EN))
    else $error("stab moved");
  ovr_read_a: assert property (RD && ADDR == 16'h8104 && $stable(CH1_OVR) |=> RDATA[8] == $past(CH1_OVR))
    else $error("overload read");
  unused_zero_a: assert property (RD && ADDR[15:2] == 14'h2041 |=> RDATA[7:3] == 5'h0 && !RDATA[0]
    && RDATA[15:9] == 7'h0) else $error("unused bits");
  clr_empty_a: assert property (csr1_wr ##0 WDATA[5] |=> ##[0:1] CH1_EMPTY) else $error("clear");
  no_ghost_a: assert property (CH1_EMPTY && !CH1_VALID |=> CH1_EMPTY) else $error("ghost");
endmodule // acs_checker
bind acs_top acs_checker i_chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .BE(BE), .WR(WR),
  .RD(RD), .RDATA(RDATA), .CH1_OVR(CH1_OVR), .CH1_VALID(CH1_VALID), .CH1_EMPTY(CH1_EMPTY),
  .CH1_STAB_EN(CH1_STAB_EN), .CH2_STAB_EN(CH2_STAB_EN));
`default_nettype wire

// file: tb/acs_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acs_top_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pop1 = 0, pop2 = 0, go = 0, ovr1 = 0, ovr2 = 0, cin = 0;
  logic [15:0] addr = 16'h0, val = 16'h0, d1, d2, pd1, pd2;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] be = 4'h0;
  logic v1, v2, e1, f1, s1, s2, e2, f2, cc1, cc2;
  int err_total = 0, total_checks = 0, hi = 0;
  initial forever #10 clk = ~clk;
  initial forever #7 cin = ~cin;
  acs_conv_model i_m1 (.clk(clk), .go(go), .val(val), .data(d1), .valid(v1));
  acs_conv_model i_m2 (.clk(clk), .go(go), .val(val), .data(d2), .valid(v2));
  acs_top i_dut (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .BE(be), .WR(wr), .RD(rd), .RDATA(rdata),
    .CONV_CLK_IN(cin), .CH1_DATA(d1), .CH1_OVR(ovr1), .CH1_VALID(v1), .CH2_DATA(d2), .CH2_OVR(ovr2),
    .CH2_VALID(v2), .CH1_POP(pop1), .CH2_POP(pop2), .CH1_POP_DATA(pd1), .CH2_POP_DATA(pd2), .CH1_EMPTY(e1),
    .CH2_EMPTY(e2), .CH1_FULL(f1), .CH2_FULL(f2), .CH1_STAB_EN(s1), .CH2_STAB_EN(s2), .CH1_CONV_CLK(cc1),
    .CH2_CONV_CLK(cc2));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrt(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    val <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic popc(input logic [15:0] e);
    @(posedge clk);
    pop1 <= 1'b1;
    @(posedge clk);
    pop1 <= 1'b0;
    #1 chk("pop", {16'h0, e}, {16'h0, pd1});
  endtask
  task automatic pop2c(input logic [15:0] e);
    @(posedge clk);
    pop2 <= 1'b1;
    @(posedge clk);
    pop2 <= 1'b0;
    #1 chk("pop2", {16'h0, e}, {16'h0, pd2});
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(16'h8104, 32'h0);
    rdc(16'h8106, 32'h0);
    wrt(16'h8104, 32'hFFFF_FFDF, 4'hF);
    rdc(16'h8104, 32'h0006_0006);
    chk("stab", 32'h3, {30'h0, s2, s1});
    repeat (16) begin
      @(cin);
      #1 hi = hi + cc1 + cc2;
    end
    chk("duty", 32'h10, hi);
    wrt(16'h8106, 32'h0, 4'h1);
    rdc(16'h8104, 32'h0000_0006);
    rdc(16'h8108, 32'h0);
    @(posedge clk);
    ovr1 <= 1'b1;
    ovr2 <= 1'b1;
    rdc(16'h8104, 32'h0100_0106);
    rdc(16'h8106, 32'h0000_0100);
    wrt(16'h8100, 32'h20, 4'h1);
    smp(16'h8001);
    chk("empty", 32'h0, {31'h0, e1});
    popc(16'h0001);
    wrt(16'h8104, 32'h0, 4'h3);
    smp(16'h8001);
    popc(16'h8001);
    for (int i = 0; i < 17; i++) smp(i[15:0]);
    chk("full", 32'h1, {31'h0, f1});
    popc(16'h0000);
    wrt(16'h8104, 32'h20, 4'h1);
    @(posedge clk);
    #1 chk("cleared", 32'h1, {31'h0, e1});
    wrt(16'h8100, 32'h0, 4'h1);
    smp(16'h1234);
    chk("stopped", 32'h1, {31'h0, e1});
    wrt(16'h8106, 32'h2, 4'h3);
    rdc(16'h8104, 32'h0102_0100);
    wrt(16'h8100, 32'h40, 4'h1);
    smp(16'h8001);
    chk("ch1 idle", 32'h1, {31'h0, e1});
    chk("ch2 stored", 32'h0, {31'h0, e2});
    chk("ch2 full", 32'h0, {31'h0, f2});
    pop2c(16'h0001);
    smp(16'h0005);
    wrt(16'h8104, 32'h0020_0000, 4'h4);
    #1 chk("ch2 cleared", 32'h1, {31'h0, e2});
    wrt(16'h8104, 32'h0006_0006, 4'hF);
    smp(16'h0007);
    chk("ch2 pushed", 32'h0, {31'h0, e2});
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc(16'h8104, 32'h0100_0100);
    chk("reset", 32'hC, {28'h0, e2, e1, s2, s1});
    test_done;
  end
endmodule // acs_top_tb
`default_nettype wire
